/* hw/cis_map.vh */
// Constants for the interrupt entry and stack unit
`ifndef CIS_MAP_VH
`define CIS_MAP_VH

// ============================================================
// I/O space offsets (6-bit direct I/O addresses)
`define CIS_OFS_PEND      6'h3A
`define CIS_OFS_ENABLE    6'h3B
`define CIS_OFS_STACK     6'h3D
`define CIS_OFS_FLAGS     6'h3F

// ============================================================
// Field positions and reset values
`define CIS_GIE_BIT       7
`define CIS_STACK_RST     8'hDF
`define CIS_FLAGS_RST     8'h00
`define CIS_ENABLE_RST    8'h00
`define CIS_STACK_FLOOR   8'h60

// ============================================================
// Vector layout: source i vectors to base + (i + 1) * step
`define CIS_VEC_BASE      16'h0000
`define CIS_VEC_STEP      16'h0001

// ============================================================
// Instruction classes reported at each instruction boundary
`define CIS_OP_OTHER      3'h0
`define CIS_OP_PUSH       3'h1
`define CIS_OP_POP        3'h2
`define CIS_OP_CALL       3'h3
`define CIS_OP_RET        3'h4
`define CIS_OP_IRQ_RETURN_INSTRUCTION       3'h5
`define CIS_OP_CLI        3'h6
`define CIS_OP_SEI        3'h7

// ============================================================
// Last count of each sequence; each runs for this value plus one clock cycles
`define CIS_ENTRY_CYC     2'h3
`define CIS_RETURN_CYC    2'h3
`define CIS_WAKE_CYC      2'h3

`endif

/* hw/cis_core.v */
// Stack address and interrupt entry/return unit of the processor core
`timescale 1ns/100ps
`include "cis_map.vh"

// ============================================================
// Overview of operation
// RULE1: Push decrements, pop increments stack address by one
// RULE2: Call or interrupt entry lowers address by two
// RULE3: Return or interrupt return raises address by two
// RULE4: Software sets stack above data start first
// RULE5: Stack address is one 8-bit I/O register
// RULE6: Core runs on undivided clock, fetch overlapped
// RULE7: Take interrupt only if individual and global enabled
// RULE8: Lowest vector wins; request zero ranks first
// RULE9: Accepting an interrupt clears global enable
// RULE10: Interrupt return sets global enable
// RULE11: Vectoring clears the event pending flag
// RULE12: Writing one clears a flag, zero keeps
// RULE13: Disabled flags stay pending, served by priority
// RULE14: Level sources request only while present
// RULE15: One instruction runs after interrupt return
// RULE16: Flags register never saved or restored automatically
// RULE17: Global disable blocks interrupts in same cycle
// RULE18: Instruction after global enable runs first
// RULE19: Entry takes four cycles, pushes program counter
// RULE20: Multi-cycle instruction finishes before entry
// RULE21: Wake from sleep adds four entry cycles
// RULE22: Return takes four cycles, restores counter, sets enable
// ============================================================

module cis_core #(
	parameter NSRC     = 8,
	parameter LVL_MASK = 8'hC0
) (
	input  wire             clock,
	input  wire             rstn,
	input  wire [5:0]       io_addr,
	input  wire             io_wr,
	input  wire [7:0]       io_wdata,
	output reg  [7:0]       io_rdata_q,
	input  wire             ins_done,
	input  wire [2:0]       ins_op,
	input  wire [15:0]      pc_in,
	input  wire             core_asleep,
	input  wire [NSRC-1:0]  src_in,
	input  wire [7:0]       mem_rdata,
	output reg              mem_we_q,
	output reg              mem_re_q,
	output reg  [7:0]       mem_addr_q,
	output reg  [7:0]       mem_wdata_q,
	output reg              pc_load_q,
	output reg  [15:0]      pc_value_q,
	output reg              core_hold_q,
	output reg              irq_ack_q,
	output reg  [7:0]       top_of_stack_address_q,
	output reg  [7:0]       flags_register_q,
	output reg  [NSRC-1:0]  pend_q
);

	// ============================================================
	// Sequencer states
	localparam ST_IDLE = 2'd0;
	localparam ST_WAKE = 2'd1;
	localparam ST_PUSH = 2'd2;
	localparam ST_POP  = 2'd3;

	reg  [1:0]      st_q;
	reg  [1:0]      cnt_q;
	reg             seq_irq_q;
	reg             seq_irq_return_instruction_q;
	reg             shield_q;
	reg  [15:0]     pc_save_q;
	reg  [7:0]      ret_hi_q;
	reg  [15:0]     vec_q;
	reg  [7:0]      enable_q;
	reg  [NSRC-1:0] req;
	reg             any_req;
	reg  [15:0]     win_vec;
	reg  [NSRC-1:0] win_onehot;
	reg  [7:0]      pend_byte;
	integer         i;

	wire gie      = flags_register_q[`CIS_GIE_BIT];
	wire wr_stack = io_wr && (io_addr == `CIS_OFS_STACK);
	wire wr_flags = io_wr && (io_addr == `CIS_OFS_FLAGS);
	wire wr_en    = io_wr && (io_addr == `CIS_OFS_ENABLE);
	wire wr_pend  = io_wr && (io_addr == `CIS_OFS_PEND);

	// CALL/RET/IRQ_RETURN_INSTRUCTION are handed to the sequencer, so an interrupt waits
	// for them to finish; CLI and SEI never open a window themselves.
	wire op_plain = (ins_op == `CIS_OP_OTHER) ||
		(ins_op == `CIS_OP_PUSH) ||
		(ins_op == `CIS_OP_POP);                       // RULE17 RULE18
	wire boundary = (st_q == ST_IDLE) &&
		((ins_done && op_plain) || core_asleep);       // RULE20
	wire take     = boundary && gie && !shield_q && any_req; // RULE7 RULE15
	wire start_call = (st_q == ST_IDLE) && ins_done &&
		(ins_op == `CIS_OP_CALL);
	wire start_ret  = (st_q == ST_IDLE) && ins_done &&
		((ins_op == `CIS_OP_RET) || (ins_op == `CIS_OP_IRQ_RETURN_INSTRUCTION));

	// ============================================================
	// Per-source pending state: event sources latch, level sources don't
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1) begin : g_src
			if (LVL_MASK[g]) begin : g_lvl
				// Follows the condition; no memory of a vanished level
				always @(posedge clock or negedge rstn) begin
					if (!rstn)
						pend_q[g] <= 1'b0;
					else
						pend_q[g] <= src_in[g];        // RULE14
				end
			end else begin : g_evt
				// Set beats both clears so a coincident event is kept
				always @(posedge clock or negedge rstn) begin
					if (!rstn)
						pend_q[g] <= 1'b0;
					else if (src_in[g])
						pend_q[g] <= 1'b1;             // RULE13
					else if (take && win_onehot[g])
						pend_q[g] <= 1'b0;             // RULE11
					else if (wr_pend && io_wdata[g])
						pend_q[g] <= 1'b0;             // RULE12
				end
			end
		end
	endgenerate

	// ============================================================
	// Fixed priority: scan from the highest index down so index 0 ends
	// as the winner; index 0 is external_request_zero.
	always @* begin
		pend_byte  = 8'h00;
		pend_byte[NSRC-1:0] = pend_q;
		req        = pend_q & enable_q[NSRC-1:0];          // RULE7
		any_req    = |req;
		win_vec    = `CIS_VEC_BASE;
		win_onehot = {NSRC{1'b0}};
		for (i = NSRC - 1; i >= 0; i = i - 1) begin
			if (req[i]) begin
				win_vec    = `CIS_VEC_BASE +
					`CIS_VEC_STEP * (i[15:0] + 16'h0001); // RULE8
				win_onehot = {NSRC{1'b0}};
				win_onehot[i] = 1'b1;
			end
		end
	end

	// ============================================================
	// Flags register: only the global enable is touched by hardware.
	// Nothing here copies it to the stack; handlers must save it.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			flags_register_q <= `CIS_FLAGS_RST;
		end else if (take) begin
			flags_register_q[`CIS_GIE_BIT] <= 1'b0;          // RULE9 RULE16
		end else if (st_q == ST_POP && cnt_q == `CIS_RETURN_CYC &&
			seq_irq_return_instruction_q) begin
			flags_register_q[`CIS_GIE_BIT] <= 1'b1;          // RULE10 RULE22
		end else if (ins_done && ins_op == `CIS_OP_CLI) begin
			flags_register_q[`CIS_GIE_BIT] <= 1'b0;          // RULE17
		end else if (ins_done && ins_op == `CIS_OP_SEI) begin
			flags_register_q[`CIS_GIE_BIT] <= 1'b1;
		end else if (wr_flags) begin
			flags_register_q <= io_wdata;
		end
	end

	// ============================================================
	// One-instruction shield after SEI or interrupt return
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			shield_q <= 1'b0;
		else if (st_q == ST_POP && cnt_q == `CIS_RETURN_CYC && seq_irq_return_instruction_q)
			shield_q <= 1'b1;                               // RULE15
		else if (ins_done && ins_op == `CIS_OP_SEI)
			shield_q <= 1'b1;                               // RULE18
		else if (ins_done)
			shield_q <= 1'b0;
	end

	// ============================================================
	// Individual enables
	always @(posedge clock or negedge rstn) begin
		if (!rstn)
			enable_q <= `CIS_ENABLE_RST;
		else if (wr_en)
			enable_q <= io_wdata;
	end

	// ============================================================
	// Sequencer: wake delay, return-address push, return-address pop.
	// Each sequence is a fixed four cycles so timing never varies.
	// Every register runs straight off the undivided core clock.
	always @(posedge clock or negedge rstn) begin           // RULE6
		if (!rstn) begin
			st_q       <= ST_IDLE;
			cnt_q      <= 2'h0;
			seq_irq_q  <= 1'b0;
			seq_irq_return_instruction_q <= 1'b0;
			pc_save_q  <= 16'h0000;
			vec_q      <= 16'h0000;
		end else begin
			case (st_q)
				ST_IDLE: begin
					cnt_q <= 2'h0;
					if (take) begin
						seq_irq_q <= 1'b1;
						pc_save_q <= pc_in;
						vec_q     <= win_vec;
						st_q      <= core_asleep ? ST_WAKE : ST_PUSH; // RULE21
					end else if (start_call) begin
						seq_irq_q <= 1'b0;
						pc_save_q <= pc_in;
						st_q      <= ST_PUSH;
					end else if (start_ret) begin
						seq_irq_return_instruction_q <= (ins_op == `CIS_OP_IRQ_RETURN_INSTRUCTION);
						st_q       <= ST_POP;
					end
				end
				ST_WAKE: begin
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == `CIS_WAKE_CYC) begin
						cnt_q <= 2'h0;
						st_q  <= ST_PUSH;                   // RULE21
					end
				end
				ST_PUSH: begin
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == `CIS_ENTRY_CYC)
						st_q <= ST_IDLE;                    // RULE19
				end
				ST_POP: begin
					cnt_q <= cnt_q + 2'h1;
					if (cnt_q == `CIS_RETURN_CYC)
						st_q <= ST_IDLE;                    // RULE22
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ============================================================
	// Stack address: an I/O write has priority since the core is
	// stalled while a sequence runs, so the two never meet in practice.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			top_of_stack_address_q <= `CIS_STACK_RST;
		end else if (wr_stack) begin
			top_of_stack_address_q <= io_wdata;             // RULE5
		end else if (st_q == ST_PUSH && cnt_q < 2'h2) begin
			top_of_stack_address_q <=
				top_of_stack_address_q - 8'h01;             // RULE2
		end else if (st_q == ST_POP && cnt_q < 2'h2) begin
			top_of_stack_address_q <=
				top_of_stack_address_q + 8'h01;             // RULE3
		end else if (st_q == ST_IDLE && ins_done &&
			ins_op == `CIS_OP_PUSH) begin
			top_of_stack_address_q <=
				top_of_stack_address_q - 8'h01;             // RULE1
		end else if (st_q == ST_IDLE && ins_done &&
			ins_op == `CIS_OP_POP) begin
			top_of_stack_address_q <=
				top_of_stack_address_q + 8'h01;             // RULE1
		end
	end

	// ============================================================
	// Stack memory port: push low byte first, pop high byte first.
	// Read data is expected one cycle after the read strobe.
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			mem_we_q    <= 1'b0;
			mem_re_q    <= 1'b0;
			mem_addr_q  <= 8'h00;
			mem_wdata_q <= 8'h00;
		end else begin
			mem_we_q <= (st_q == ST_PUSH) && (cnt_q < 2'h2);
			mem_re_q <= (st_q == ST_POP) && (cnt_q < 2'h2);
			if (st_q == ST_PUSH && cnt_q < 2'h2) begin
				mem_addr_q  <= top_of_stack_address_q;      // RULE19
				mem_wdata_q <= (cnt_q == 2'h0) ?
					pc_save_q[7:0] : pc_save_q[15:8];
			end else if (st_q == ST_POP && cnt_q < 2'h2) begin
				mem_addr_q <= top_of_stack_address_q + 8'h01; // RULE22
			end
		end
	end

	// ============================================================
	// Program counter hand-back at the last cycle of a sequence
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			ret_hi_q   <= 8'h00;
			pc_load_q  <= 1'b0;
			pc_value_q <= 16'h0000;
		end else begin
			pc_load_q <= 1'b0;
			if (st_q == ST_POP && cnt_q == 2'h2)
				ret_hi_q <= mem_rdata;
			if (st_q == ST_POP && cnt_q == `CIS_RETURN_CYC) begin
				pc_load_q  <= 1'b1;                         // RULE22
				pc_value_q <= {ret_hi_q, mem_rdata};
			end else if (st_q == ST_PUSH && cnt_q == `CIS_ENTRY_CYC &&
				seq_irq_q) begin
				pc_load_q  <= 1'b1;                         // RULE19
				pc_value_q <= vec_q;
			end
		end
	end

	// ============================================================
	// Core handshake: hold the core while any sequence runs
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			core_hold_q <= 1'b0;
			irq_ack_q   <= 1'b0;
		end else begin
			irq_ack_q <= take;
			if (take || start_call || start_ret)
				core_hold_q <= 1'b1;
			else if (st_q != ST_IDLE && st_q != ST_WAKE &&
				cnt_q == 2'h3)
				core_hold_q <= 1'b0;
		end
	end

	// ============================================================
	// I/O read port, registered; unmapped offsets read zero
	always @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			io_rdata_q <= 8'h00;
		end else begin
			case (io_addr)
				`CIS_OFS_STACK:  io_rdata_q <= top_of_stack_address_q;
				`CIS_OFS_FLAGS:  io_rdata_q <= flags_register_q;
				`CIS_OFS_ENABLE: io_rdata_q <= enable_q;
				`CIS_OFS_PEND:   io_rdata_q <= pend_byte;
				default:         io_rdata_q <= 8'h00;
			endcase
		end
	end

endmodule // cis_core

/* dv/cis_core_properties.sv */
// Assertions on the ports of the interrupt entry and stack unit
`timescale 1ns/100ps
`include "cis_map.vh"

module cis_core_properties (
	input logic       clock,
	input logic       rstn,
	input logic       ins_done,
	input logic [2:0] ins_op,
	input logic       core_asleep,
	input logic       mem_we_q,
	input logic [7:0] mem_addr_q,
	input logic       pc_load_q,
	input logic       core_hold_q,
	input logic       irq_ack_q,
	input logic [7:0] top_of_stack_address_q,
	input logic [7:0] flags_register_q
);
	// ============================================================
	// Shorthands
	wire [7:0] sp = top_of_stack_address_q;
	wire       gie = flags_register_q[`CIS_GIE_BIT];
	wire       b = ins_done;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	// ============================================================
	// Entry steps: hold, then the vector load as hold falls
	sequence s_awake;
		core_hold_q [*4] ##1 (pc_load_q && !core_hold_q);
	endsequence
	sequence s_sleep;
		core_hold_q [*8] ##1 (pc_load_q && !core_hold_q);
	endsequence
	// Return address goes out as two bytes on falling addresses
	sequence s_push2;
		mem_we_q && mem_addr_q == $past(sp) ##1
		mem_we_q && mem_addr_q == $past(sp, 2) - 8'h01;
	endsequence

	// ============================================================
	// Properties
	AST_PUSH: assert property (
		b && ins_op == `CIS_OP_PUSH && !gie |=> sp == $past(sp) - 8'h01)
		else $error("push step wrong");
	AST_POP: assert property (
		b && ins_op == `CIS_OP_POP && !gie |=> sp == $past(sp) + 8'h01)
		else $error("pop step wrong");
	AST_CALL: assert property (
		b && ins_op == `CIS_OP_CALL |-> ##5 sp == $past(sp, 5) - 8'h02)
		else $error("call step wrong");
	AST_RETURN: assert property (
		b && (ins_op == `CIS_OP_RET || ins_op == `CIS_OP_IRQ_RETURN_INSTRUCTION)
		|-> ##5 pc_load_q && sp == $past(sp, 5) + 8'h02)
		else $error("return step or timing wrong");
	AST_IRQ_RETURN_INSTRUCTION_GIE: assert property (
		b && ins_op == `CIS_OP_IRQ_RETURN_INSTRUCTION |-> ##5 gie)
		else $error("global enable not set on return");
	AST_ENTRY_AWAKE: assert property (
		irq_ack_q && !$past(core_asleep) |-> s_awake)
		else $error("entry timing wrong");
	AST_ENTRY_SLEEP: assert property (
		irq_ack_q && $past(core_asleep) |-> s_sleep)
		else $error("sleep entry timing wrong");
	AST_ENTRY_STACK: assert property (
		irq_ack_q && !$past(core_asleep)
		|=> s_push2 ##3 sp == $past(sp, 5) - 8'h02)
		else $error("entry stack save wrong");
	AST_ENTRY_GIE: assert property (
		irq_ack_q |-> $past(gie) && !gie &&
		flags_register_q[6:0] == $past(flags_register_q[6:0]))
		else $error("flags wrong at entry");
	AST_CLI: assert property (
		b && ins_op == `CIS_OP_CLI |=> !irq_ack_q [*3])
		else $error("entry after disable");
	AST_SEI: assert property (
		b && ins_op == `CIS_OP_SEI ##[1:2] b |=> !irq_ack_q)
		else $error("entry before next instruction");
	AST_IRQ_RETURN_INSTRUCTION_NEXT: assert property (
		b && ins_op == `CIS_OP_IRQ_RETURN_INSTRUCTION ##5 pc_load_q ##[1:2] b |=> !irq_ack_q)
		else $error("entry right after return");
endmodule // cis_core_properties

bind cis_core cis_core_properties i_cis_core_properties (.clock, .rstn,
	.ins_done, .ins_op, .core_asleep, .mem_we_q, .mem_addr_q, .pc_load_q,
	.core_hold_q, .irq_ack_q, .top_of_stack_address_q, .flags_register_q);

/* dv/cis_stack_ram.sv */
// Stack memory model on the far side of the unit's stack strobes
`timescale 1ns/100ps

module cis_stack_ram (
	input  logic       clock,
	input  logic       mem_we_q,
	input  logic       mem_re_q,
	input  logic [7:0] mem_addr_q,
	input  logic [7:0] mem_wdata_q,
	output logic [7:0] mem_rdata
);
	logic [7:0] mem [0:255];

	// Data is valid only the cycle after a read; otherwise the inverse
	// of the last output shows, so a stale byte comes back every second cycle
	initial mem_rdata = 8'h00;
	always @(posedge clock) begin
		if (mem_we_q)
			mem[mem_addr_q] <= mem_wdata_q;
		mem_rdata <= mem_re_q ? mem[mem_addr_q] : ~mem_rdata;
	end
endmodule // cis_stack_ram

/* dv/cis_core_bench.sv */
// Self-checking bench for the interrupt entry and stack unit
`timescale 1ns/100ps
`include "cis_map.vh"

module cis_core_bench;
	logic        clock = 0, rstn = 0, io_wr = 0, ins_done = 0;
	logic        core_asleep = 0, acked, loaded;
	logic [5:0]  io_addr = 0;
	logic [2:0]  ins_op = 0;
	logic [7:0]  io_wdata = 0, src_in = 0, io_rdata_q, mem_rdata;
	logic [7:0]  mem_addr_q, mem_wdata_q, sp, flg, pend;
	logic [15:0] pc_in = 16'h1234, pc_value_q, lpc;
	logic        mem_we_q, mem_re_q, pc_load_q, core_hold_q, irq_ack_q;
	integer      num_errors = 0, compares = 0;

	always #10 clock = ~clock;

	cis_core i_cis_core (.clock, .rstn, .io_addr, .io_wr, .io_wdata,
		.io_rdata_q, .ins_done, .ins_op, .pc_in, .core_asleep, .src_in,
		.mem_rdata, .mem_we_q, .mem_re_q, .mem_addr_q, .mem_wdata_q,
		.pc_load_q, .pc_value_q, .core_hold_q, .irq_ack_q,
		.top_of_stack_address_q(sp), .flags_register_q(flg), .pend_q(pend));
	cis_stack_ram i_cis_stack_ram (.clock, .mem_we_q, .mem_re_q,
		.mem_addr_q, .mem_wdata_q, .mem_rdata);

	// ============================================================
	// Access tasks
	task chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock);
		io_addr = a;
		io_wr = 1;
		io_wdata = d;
		@(negedge clock);
		io_wr = 0;
	endtask
	task rd(input logic [5:0] a, input logic [7:0] e);
		@(negedge clock);
		io_addr = a;
		@(negedge clock);
		chk(io_rdata_q, e);
	endtask
	// One boundary (p) and/or a source pulse (s); then follow any entry
	// or return until hold drops, noting the loaded address
	task run(input logic [2:0] o, input logic p, input logic [7:0] s);
		integer n;
		acked = 0;
		loaded = 0;
		@(negedge clock);
		src_in = src_in | s;
		ins_done = p;
		ins_op = o;
		@(negedge clock);
		src_in = src_in & ~s;
		ins_done = 0;
		for (n = 0; n < 12 && !p && irq_ack_q !== 1; n++)
			@(negedge clock);
		acked = (irq_ack_q === 1);
		for (n = 0; n < 16 && core_hold_q === 1; n++) begin
			@(negedge clock);
			if (pc_load_q === 1) begin
				loaded = 1;
				lpc = pc_value_q;
			end
		end
	endtask
	task summarize;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ============================================================
	// Watchdog: the run needs well under 1000 cycles
	initial begin
		#50000;
		num_errors++;
		summarize;
	end

	// ============================================================
	// Tests
	initial begin
		repeat (12) @(negedge clock);
		rstn = 1;
		rd(`CIS_OFS_STACK, `CIS_STACK_RST);
		rd(`CIS_OFS_FLAGS, 8'h00);
		rd(`CIS_OFS_ENABLE, 8'h00);
		rd(`CIS_OFS_PEND, 8'h00);
		rd(6'h10, 8'h00);
		wr(`CIS_OFS_STACK, 8'h80);
		rd(`CIS_OFS_STACK, 8'h80);
		run(`CIS_OP_PUSH, 1, 0);
		chk(sp, 8'h7F);
		run(`CIS_OP_POP, 1, 0);
		chk(sp, 8'h80);
		run(`CIS_OP_CALL, 1, 0);
		chk(sp, 8'h7E);
		run(`CIS_OP_RET, 1, 0);
		chk(lpc, 16'h1234);
		chk(sp, 8'h80);
		pc_in = 16'h0ABC;
		wr(`CIS_OFS_FLAGS, 8'h25);
		wr(`CIS_OFS_ENABLE, 8'hEF);
		run(`CIS_OP_OTHER, 0, 8'h38);
		chk(pend, 8'h38);
		wr(`CIS_OFS_PEND, 8'h00);
		chk(pend, 8'h38);
		wr(`CIS_OFS_PEND, 8'h08);
		chk(pend, 8'h30);
		run(`CIS_OP_OTHER, 0, 8'h08);
		run(`CIS_OP_SEI, 1, 0);
		run(`CIS_OP_OTHER, 1, 0);
		chk(acked, 0);
		run(`CIS_OP_OTHER, 1, 0);
		chk(lpc, 16'h0004);
		chk(pend, 8'h30);
		chk(flg, 8'h25);
		chk(sp, 8'h7E);
		run(`CIS_OP_IRQ_RETURN_INSTRUCTION, 1, 0);
		chk(lpc, 16'h0ABC);
		chk(flg, 8'hA5);
		run(`CIS_OP_OTHER, 1, 0);
		chk(acked, 0);
		run(`CIS_OP_OTHER, 1, 0);
		chk(lpc, 16'h0006);
		chk(pend, 8'h10);
		run(`CIS_OP_IRQ_RETURN_INSTRUCTION, 1, 0);
		run(`CIS_OP_CLI, 1, 8'h08);
		run(`CIS_OP_OTHER, 1, 0);
		chk(acked, 0);
		chk(pend, 8'h18);
		wr(`CIS_OFS_PEND, 8'hFF);
		chk(pend, 8'h00);
		// Level source comes and goes while disabled
		src_in = 8'h80;
		run(`CIS_OP_OTHER, 0, 0);
		src_in = 8'h00;
		run(`CIS_OP_SEI, 1, 0);
		run(`CIS_OP_OTHER, 1, 0);
		run(`CIS_OP_OTHER, 1, 0);
		chk(acked, 0);
		src_in = 8'h40;
		run(`CIS_OP_OTHER, 1, 0);
		chk(lpc, 16'h0007);
		src_in = 8'h00;
		run(`CIS_OP_IRQ_RETURN_INSTRUCTION, 1, 0);
		run(`CIS_OP_OTHER, 1, 0);
		// Request lands as a call starts: waits out call and return,
		// then wins at the next plain boundary
		run(`CIS_OP_CALL, 1, 8'h08);
		chk(acked, 0);
		run(`CIS_OP_RET, 1, 0);
		chk(acked, 0);
		chk(lpc, 16'h0ABC);
		run(`CIS_OP_OTHER, 1, 0);
		chk(lpc, 16'h0004);
		run(`CIS_OP_IRQ_RETURN_INSTRUCTION, 1, 0);
		run(`CIS_OP_OTHER, 1, 0);
		// Wake from sleep by request zero
		core_asleep = 1;
		run(`CIS_OP_OTHER, 0, 8'h01);
		chk(lpc, 16'h0001);
		core_asleep = 0;
		run(`CIS_OP_IRQ_RETURN_INSTRUCTION, 1, 0);
		summarize;
	end
endmodule // cis_core_bench
